/* logic/csa_map.svh */
`ifndef CSA_MAP_SVH
`define CSA_MAP_SVH

// Register byte offsets
`define STATUS_OFS   12'h000
`define CONTROL_OFS  12'h004

// Status word fields
`define SW_DC        8
`define SW_IPL_HI    7
`define SW_IPL_LO    5
`define SW_RA        4
`define SW_N         3
`define SW_OV        2
`define SW_Z         1
`define SW_C         0

// Control word fields
`define CW_US        12
`define CW_EDT       11
`define CW_DL_HI     10
`define CW_DL_LO     8
`define CW_ACC_A_CLAMP_ENABLE      7
`define CW_ACC_B_CLAMP_ENABLE      6
`define CW_STORE_CLAMP_ENABLE     5
`define CW_CLAMP_WIDTH_SELECT    4
`define CW_CPU_PRIORITY_MSB      3
`define CW_PSV       2
`define CW_RND       1
`define CW_IF        0

// Reset values
`define STORE_CLAMP_ENABLE_RST    1'b1
`define IPL_RST      3'h0

// Divider timing
`define DIV_STEPS    5'h10

`endif

/* logic/csa_pkg.sv */
package csa_pkg;

	typedef enum logic [2:0] {
		ALU_ADD, ALU_SUB, ALU_AND, ALU_IOR,
		ALU_XOR, ALU_SHL, ALU_LSR, ALU_ASR
	} alu_op_t;

	typedef enum logic [2:0] {
		MUL_SS, MUL_UU, MUL_SU, MUL_US,
		MUL_SLIT, MUL_ULIT, MUL_BYTE
	} mul_mode_t;

	typedef enum logic [1:0] {
		DIV_IDLE, DIV_RUN, DIV_FIX
	} div_state_t;

endpackage

/* logic/div_if.sv */
`timescale 1ns/100ps
interface div_if;
	logic        go;
	logic        sgn;
	logic        wide;
	logic [31:0] dividend;
	logic [15:0] divisor;
	logic        busy;
	logic        done;
	logic        err;
	logic [15:0] quot;
	logic [15:0] rem;

	modport requester (output go, sgn, wide, dividend, divisor,
		input busy, done, err, quot, rem);
	modport engine (input go, sgn, wide, dividend, divisor,
		output busy, done, err, quot, rem);
endinterface

/* logic/div_engine.sv */
`timescale 1ns/100ps
`include "csa_map.svh"
module div_engine
	import csa_pkg::*;
(
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Divide request and answer
	div_if.engine     d
);
	div_state_t  state_r;
	logic [4:0]  cnt_r;
	logic [15:0] rem_r;
	logic [15:0] q_r;
	logic [15:0] dvs_r;
	logic        neg_q_r;
	logic        neg_r_r;
	logic        err_r;
	logic        done_r;
	logic [15:0] quot_r;
	logic [15:0] remo_r;
	logic [31:0] dd;
	logic [31:0] dd_mag;
	logic [15:0] dv_mag;
	logic [16:0] trial;
	logic        fits;

	always_comb
	begin
		dd = d.wide ? d.dividend : {{16{d.sgn & d.dividend[15]}}, d.dividend[15:0]};
		dd_mag = (d.sgn && dd[31]) ? 32'(-dd) : dd;
		dv_mag = (d.sgn && d.divisor[15]) ? 16'(-d.divisor) : d.divisor;
		trial = {rem_r, q_r[15]};
		fits = trial >= {1'b0, dvs_r};
	end

	// One step per divisor bit, same for both dividend sizes
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_r <= DIV_IDLE;
			cnt_r <= 5'h00;
			rem_r <= 16'h0000;
			q_r <= 16'h0000;
			dvs_r <= 16'h0000;
			neg_q_r <= 1'b0;
			neg_r_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				DIV_IDLE:
					if (d.go)
					begin
						rem_r <= dd_mag[31:16];
						q_r <= dd_mag[15:0];
						dvs_r <= dv_mag;
						neg_q_r <= d.sgn & (dd[31] ^ d.divisor[15]);
						neg_r_r <= d.sgn & dd[31];
						cnt_r <= `DIV_STEPS;
						state_r <= DIV_RUN;
					end
				DIV_RUN:
				begin
					rem_r <= fits ? 16'(trial - {1'b0, dvs_r}) : trial[15:0];
					q_r <= {q_r[14:0], fits};
					cnt_r <= cnt_r - 5'h01;
					if (cnt_r == 5'h01)
						state_r <= DIV_FIX;
				end
				DIV_FIX:
					state_r <= DIV_IDLE;
				default:
					state_r <= DIV_IDLE;
			endcase
		end
	end

	// Sign fix-up and answer; quotient for W0, remainder for W1
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			done_r <= 1'b0;
			err_r <= 1'b0;
			quot_r <= 16'h0000;
			remo_r <= 16'h0000;
		end
		else
		begin
			done_r <= state_r == DIV_FIX;
			if (state_r == DIV_IDLE && d.go)
				err_r <= (dv_mag == 16'h0000) || (dd_mag[31:16] >= dv_mag);
			if (state_r == DIV_FIX)
			begin
				quot_r <= neg_q_r ? 16'(-q_r) : q_r;
				remo_r <= neg_r_r ? 16'(-rem_r) : rem_r;
			end
		end
	end

	assign d.busy = state_r != DIV_IDLE;
	assign d.done = done_r;
	assign d.err  = err_r;
	assign d.quot = quot_r;
	assign d.rem  = remo_r;
endmodule

/* logic/cpu_status_alu_multiply_divide.sv */
`timescale 1ns/100ps
`include "csa_map.svh"
module cpu_status_alu_multiply_divide
	import csa_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              rst,
	// APB slave
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [31:0]       pwdata,
	output logic [31:0]            prdata,
	output logic                   pready,
	output logic                   pslverr,
	// ALU request from decode
	input  wire logic              alu_go,
	input  wire alu_op_t           alu_op,
	input  wire logic              alu_byte,
	input  wire logic              alu_z_keep,
	input  wire logic              alu_cin,
	input  wire logic [15:0]       alu_a,
	input  wire logic [15:0]       alu_b,
	output logic [15:0]            alu_result,
	// Multiplier request
	input  wire logic              mul_go,
	input  wire logic              mul_dsp,
	input  wire mul_mode_t         mul_mode,
	input  wire logic [15:0]       mul_a,
	input  wire logic [15:0]       mul_b,
	output logic [39:0]            mul_product,
	output logic                   mul_valid,
	// Divider request
	input  wire logic              div_go,
	input  wire logic              div_signed,
	input  wire logic              div_wide,
	input  wire logic [31:0]       div_dividend,
	input  wire logic [15:0]       div_divisor,
	output logic [15:0]            div_quot,
	output logic [15:0]            div_rem,
	output logic                   div_done,
	output logic                   div_busy,
	output logic                   div_err,
	// Sequencer status and priority
	input  wire logic              repeat_active,
	input  wire logic [2:0]        loop_nesting_depth,
	input  wire logic              nesting_disable,
	input  wire logic              prio_load,
	input  wire logic [3:0]        prio_value,
	output logic [3:0]             cpu_priority_level,
	output logic                   user_irq_disable,
	output logic [15:0]            cpu_status_word,
	output logic [15:0]            core_control_word,
	// Engine configuration
	output logic                   dsp_unsigned_select,
	output logic                   early_loop_exit,
	output logic                   acc_a_clamp_enable,
	output logic                   acc_b_clamp_enable,
	output logic                   store_clamp_enable,
	output logic                   clamp_width_select,
	output logic                   program_window_enable,
	output logic                   round_style_select,
	output logic                   int_mode_select
);
	div_if dif ();

	logic        acc_ph;
	logic        setup_ph;
	logic        hit_sw;
	logic        hit_cw;
	logic        wr_sw;
	logic        wr_cw;
	logic [15:0] rd_word;
	logic [31:0] prdata_r;

	logic        dc_r;
	logic        n_r;
	logic        ov_r;
	logic        z_r;
	logic        c_r;
	logic [2:0]  ipl_r;
	logic        cpu_priority_msb_r;
	logic        us_r;
	logic        edt_r;
	logic        acc_a_clamp_enable_r;
	logic        acc_b_clamp_enable_r;
	logic        store_clamp_enable_r;
	logic        clamp_width_select_r;
	logic        psv_r;
	logic        rnd_r;
	logic        if_r;

	logic [15:0] bb;
	logic [16:0] sum16;
	logic [8:0]  sum8;
	logic [4:0]  sum4;
	logic [15:0] rr;
	logic        co;
	logic        hc;
	logic        wrap;
	logic        arith;
	logic        shift;
	logic        msb_a;
	logic        msb_b;
	logic        msb_r;
	logic        zero;
	logic [15:0] result_r;

	logic        sa;
	logic        sb;
	logic [15:0] ma;
	logic [15:0] mb;
	logic [33:0] prod;
	logic [39:0] ext;
	logic [39:0] product_r;
	logic        valid_r;

	// Bus decode; no wait states
	always_comb
	begin
		setup_ph = psel & ~penable;
		acc_ph = psel & penable;
		hit_sw = paddr == ADDR_W'(`STATUS_OFS);
		hit_cw = paddr == ADDR_W'(`CONTROL_OFS);
		wr_sw = acc_ph & pwrite & hit_sw;
		wr_cw = acc_ph & pwrite & hit_cw;
		pready = 1'b1;
		pslverr = acc_ph & ~(hit_sw | hit_cw);
	end

	assign cpu_status_word = {7'h00, dc_r, ipl_r, repeat_active,
		n_r, ov_r, z_r, c_r};
	// Early exit is a strobe, so it reads back as zero
	assign core_control_word = {3'h0, us_r, 1'b0, loop_nesting_depth,
		acc_a_clamp_enable_r, acc_b_clamp_enable_r, store_clamp_enable_r, clamp_width_select_r, cpu_priority_msb_r, psv_r, rnd_r, if_r};
	assign rd_word = hit_sw ? cpu_status_word : hit_cw ? core_control_word : 16'h0000;

	// Read data captured in setup so it comes from a flop
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			prdata_r <= 32'h00000000;
		else if (setup_ph && !pwrite)
			prdata_r <= {16'h0000, rd_word};
	end
	assign prdata = prdata_r;

	// ALU datapath
	always_comb
	begin
		arith = (alu_op == ALU_ADD) || (alu_op == ALU_SUB);
		shift = (alu_op == ALU_SHL) || (alu_op == ALU_LSR) || (alu_op == ALU_ASR);
		bb = (alu_op == ALU_SUB) ? ~alu_b : alu_b;
		sum16 = {1'b0, alu_a} + {1'b0, bb} + {16'h0000, alu_cin};
		sum8 = {1'b0, alu_a[7:0]} + {1'b0, bb[7:0]} + {8'h00, alu_cin};
		sum4 = {1'b0, alu_a[3:0]} + {1'b0, bb[3:0]} + {4'h0, alu_cin};
		msb_a = alu_byte ? alu_a[7] : alu_a[15];
		msb_b = alu_byte ? bb[7] : bb[15];
		co = 1'b0;
		case (alu_op)
			ALU_ADD, ALU_SUB:
			begin
				rr = sum16[15:0];
				co = alu_byte ? sum8[8] : sum16[16];
			end
			ALU_AND: rr = alu_a & alu_b;
			ALU_IOR: rr = alu_a | alu_b;
			ALU_XOR: rr = alu_a ^ alu_b;
			ALU_SHL:
			begin
				rr = {alu_a[14:0], 1'b0};
				co = msb_a;
			end
			ALU_LSR:
			begin
				rr = alu_byte ? {8'h00, 1'b0, alu_a[7:1]} : {1'b0, alu_a[15:1]};
				co = alu_a[0];
			end
			ALU_ASR:
			begin
				rr = alu_byte ? {8'h00, alu_a[7], alu_a[7:1]} : {alu_a[15], alu_a[15:1]};
				co = alu_a[0];
			end
			default: rr = alu_a;
		endcase
		hc = alu_byte ? sum4[4] : sum8[8];
		msb_r = alu_byte ? rr[7] : rr[15];
		wrap = arith & (msb_a == msb_b) & (msb_r != msb_a);
		zero = alu_byte ? (rr[7:0] == 8'h00) : (rr == 16'h0000);
	end

	// Byte operations leave the upper byte of the operand alone
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			result_r <= 16'h0000;
		else if (alu_go)
			result_r <= alu_byte ? {alu_a[15:8], rr[7:0]} : rr;
	end
	assign alu_result = result_r;

	// Condition flags; an ALU update wins over a bus write in the same cycle
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			dc_r <= 1'b0;
			n_r <= 1'b0;
			ov_r <= 1'b0;
			z_r <= 1'b0;
			c_r <= 1'b0;
		end
		else
		begin
			if (wr_sw)
			begin
				dc_r <= pwdata[`SW_DC];
				n_r <= pwdata[`SW_N];
				ov_r <= pwdata[`SW_OV];
				z_r <= pwdata[`SW_Z];
				c_r <= pwdata[`SW_C];
			end
			if (alu_go)
			begin
				n_r <= msb_r;
				z_r <= alu_z_keep ? (z_r & zero) : zero;
				if (arith)
				begin
					dc_r <= hc;
					ov_r <= wrap;
				end
				if (arith || shift)
					c_r <= co;
			end
		end
	end

	// Priority field and its msb
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ipl_r <= `IPL_RST;
			cpu_priority_msb_r <= 1'b0;
		end
		else
		begin
			if (wr_sw && !nesting_disable)
				ipl_r <= pwdata[`SW_IPL_HI:`SW_IPL_LO];
			if (wr_cw && !pwdata[`CW_CPU_PRIORITY_MSB])
				cpu_priority_msb_r <= 1'b0;
			if (prio_load)
			begin
				ipl_r <= prio_value[2:0];
				cpu_priority_msb_r <= prio_value[3];
			end
		end
	end
	assign cpu_priority_level = {cpu_priority_msb_r, ipl_r};
	assign user_irq_disable = cpu_priority_msb_r | (&ipl_r);

	// Engine configuration bits
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			us_r <= 1'b0;
			edt_r <= 1'b0;
			acc_a_clamp_enable_r <= 1'b0;
			acc_b_clamp_enable_r <= 1'b0;
			store_clamp_enable_r <= `STORE_CLAMP_ENABLE_RST;
			clamp_width_select_r <= 1'b0;
			psv_r <= 1'b0;
			rnd_r <= 1'b0;
			if_r <= 1'b0;
		end
		else
		begin
			edt_r <= wr_cw & pwdata[`CW_EDT];
			if (wr_cw)
			begin
				us_r <= pwdata[`CW_US];
				acc_a_clamp_enable_r <= pwdata[`CW_ACC_A_CLAMP_ENABLE];
				acc_b_clamp_enable_r <= pwdata[`CW_ACC_B_CLAMP_ENABLE];
				store_clamp_enable_r <= pwdata[`CW_STORE_CLAMP_ENABLE];
				clamp_width_select_r <= pwdata[`CW_CLAMP_WIDTH_SELECT];
				psv_r <= pwdata[`CW_PSV];
				rnd_r <= pwdata[`CW_RND];
				if_r <= pwdata[`CW_IF];
			end
		end
	end
	assign dsp_unsigned_select = us_r;
	assign early_loop_exit = edt_r;
	assign acc_a_clamp_enable = acc_a_clamp_enable_r;
	assign acc_b_clamp_enable = acc_b_clamp_enable_r;
	assign store_clamp_enable = store_clamp_enable_r;
	assign clamp_width_select = clamp_width_select_r;
	assign program_window_enable = psv_r;
	assign round_style_select = rnd_r;
	assign int_mode_select = if_r;

	// Shared 17x17 multiplier; 17th bit holds sign or zero
	always_comb
	begin
		sa = 1'b0;
		sb = 1'b0;
		ma = mul_a;
		mb = mul_b;
		if (mul_dsp)
		begin
			sa = ~us_r;
			sb = ~us_r;
		end
		else
		begin
			case (mul_mode)
				MUL_SS:
				begin
					sa = 1'b1;
					sb = 1'b1;
				end
				MUL_SU: sa = 1'b1;
				MUL_US: sb = 1'b1;
				MUL_SLIT:
				begin
					sa = 1'b1;
					mb = {11'h000, mul_b[4:0]};
				end
				MUL_ULIT: mb = {11'h000, mul_b[4:0]};
				MUL_BYTE:
				begin
					ma = {8'h00, mul_a[7:0]};
					mb = {8'h00, mul_b[7:0]};
				end
				default: sa = 1'b0;
			endcase
		end
		prod = 34'($signed({sa & ma[15], ma}) * $signed({sb & mb[15], mb}));
		ext = {{7{prod[32]}}, prod[32:0]};
		if (mul_dsp && !if_r)
			ext = {ext[38:0], 1'b0};
	end

	// Byte multiplies fill only the low 16 bits; word ones extend product bit 32 up through bit 39
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			product_r <= 40'h0000000000;
			valid_r <= 1'b0;
		end
		else
		begin
			valid_r <= mul_go;
			if (mul_go)
				product_r <= ext;
		end
	end
	assign mul_product = product_r;
	assign mul_valid = valid_r;

	// Iterative divider; requests while busy are dropped
	assign dif.go = div_go & ~dif.busy;
	assign dif.sgn = div_signed;
	assign dif.wide = div_wide;
	assign dif.dividend = div_dividend;
	assign dif.divisor = div_divisor;

	div_engine u_div (
		.clk (clk),
		.rst (rst),
		.d   (dif.engine)
	);

	assign div_quot = dif.quot;
	assign div_rem = dif.rem;
	assign div_done = dif.done;
	assign div_busy = dif.busy;
	assign div_err = dif.err;
endmodule

/* tb/csa_assertions.sv */
`timescale 1ns/100ps
module csa_assertions
	import csa_pkg::*;
#(
	parameter int ADDR_W = 12
)
(
	// Clock and reset
	input wire logic              clk,
	input wire logic              rst,
	// Bus and requests
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic              alu_go,
	input wire logic              alu_byte,
	input wire logic              alu_z_keep,
	input wire logic [15:0]       alu_result,
	input wire logic              mul_go,
	input wire logic              mul_valid,
	input wire logic              div_go,
	input wire logic              div_busy,
	input wire logic              div_done,
	// Status and control
	input wire logic              repeat_active,
	input wire logic [2:0]        loop_nesting_depth,
	input wire logic              nesting_disable,
	input wire logic              prio_load,
	input wire logic [3:0]        cpu_priority_level,
	input wire logic              user_irq_disable,
	input wire logic [15:0]       cpu_status_word,
	input wire logic [15:0]       core_control_word,
	input wire logic              early_loop_exit
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// Sixteen steps plus fix-up, whatever the dividend size
	sequence s_div_run;
		div_busy [*8] ##10 div_done;
	endsequence
	sequence s_exit_write;
		psel && penable && pwrite && paddr == ADDR_W'(4) && pwdata[11];
	endsequence

	a_div_time: assert property (div_go && !div_busy |=> s_div_run)
		else $error("divide timing wrong");
	a_mul_valid: assert property (mul_go |=> mul_valid)
		else $error("product not flagged");
	a_exit_pulse: assert property (s_exit_write |=> early_loop_exit)
		else $error("loop exit pulse missing");
	a_prio_join: assert property (cpu_priority_level == {core_control_word[3], cpu_status_word[7:5]})
		else $error("priority level not joined");
	a_irq_block: assert property (user_irq_disable == (cpu_priority_level[3] | &cpu_priority_level[2:0]))
		else $error("user interrupt block wrong");
	a_prio_lock: assert property (nesting_disable && !prio_load |=> $stable(cpu_status_word[7:5]))
		else $error("locked priority field changed");
	a_repeat_view: assert property (cpu_status_word[4] == repeat_active)
		else $error("repeat bit wrong");
	a_depth_view: assert property (core_control_word[10:8] == loop_nesting_depth)
		else $error("loop depth wrong");
	a_ctl_top: assert property ({core_control_word[15:13], core_control_word[11]} == 4'h0)
		else $error("control top bits not zero");
	a_n_flag: assert property (alu_go |=> cpu_status_word[3] == ($past(alu_byte) ? alu_result[7] : alu_result[15]))
		else $error("negative flag wrong");
	a_z_sticky: assert property (alu_go && alu_z_keep && !cpu_status_word[1] |=> !cpu_status_word[1])
		else $error("kept zero flag was set");
endmodule

/* tb/loop_seq_model.sv */
`timescale 1ns/100ps
module loop_seq_model
#(
	parameter int START_DEPTH = 2,
	parameter int REP_LEN     = 4
)
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Commands and design view
	input  wire logic       rep_start,
	input  wire logic       early_loop_exit,
	output logic            repeat_active,
	output logic [2:0]      loop_nesting_depth
);
	logic [3:0] rep_cnt_r;

	// Exit ends one loop level; depth never wraps below zero
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			loop_nesting_depth <= 3'(START_DEPTH);
		else if (early_loop_exit && loop_nesting_depth != 3'h0)
			loop_nesting_depth <= loop_nesting_depth - 3'h1;
	end
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			rep_cnt_r <= 4'h0;
		else if (rep_start)
			rep_cnt_r <= 4'(REP_LEN);
		else if (rep_cnt_r != 4'h0)
			rep_cnt_r <= rep_cnt_r - 4'h1;
	end
	assign repeat_active = (rep_cnt_r != 4'h0);
endmodule

/* tb/cpu_status_alu_multiply_divide_tb_top.sv */
`timescale 1ns/100ps
module cpu_status_alu_multiply_divide_tb_top
	import csa_pkg::*;
();
	typedef struct packed {alu_op_t op; logic byt, zk, ci; logic [15:0] a, b, r; logic [4:0] f;}
		alu_row_t;
	typedef struct packed {mul_mode_t md; logic dsp; logic [15:0] a, b; logic [39:0] p;} mul_row_t;
	typedef struct packed {logic sg, wd; logic [31:0] n; logic [15:0] d, q, r; logic e;} div_row_t;
	logic        clk, rst, psel, penable, pwrite, pready, pslverr, perr, rep_start;
	logic        alu_go, alu_byte, alu_z_keep, alu_cin, mul_go, mul_dsp, mul_valid;
	logic        div_go, div_signed, div_wide, div_done, div_busy, div_err;
	logic        nesting_disable, prio_load, user_irq_disable, repeat_active, early_loop_exit;
	logic        dsp_unsigned_select, acc_a_clamp_enable, acc_b_clamp_enable, store_clamp_enable;
	logic        clamp_width_select, program_window_enable, round_style_select, int_mode_select;
	logic [2:0]  loop_nesting_depth;
	logic [3:0]  prio_value, cpu_priority_level;
	logic [4:0]  m, fl;
	logic [7:0]  cb;
	logic [11:0] paddr;
	logic [15:0] alu_a, alu_b, alu_result, mul_a, mul_b, div_divisor, div_quot, div_rem;
	logic [15:0] cpu_status_word, core_control_word;
	logic [31:0] pwdata, prdata, div_dividend, rd;
	logic [39:0] mul_product;
	alu_op_t     alu_op;
	mul_mode_t   mul_mode;
	int          error_cnt, total_checks, k;
	alu_row_t    arow [13] = '{
		'{ALU_ADD, 1'b0, 1'b0, 1'b0, 16'h7FFF, 16'h0001, 16'h8000, 5'h1C},
		'{ALU_ADD, 1'b0, 1'b0, 1'b0, 16'hFFFF, 16'h0001, 16'h0000, 5'h13},
		'{ALU_SUB, 1'b0, 1'b0, 1'b1, 16'h0005, 16'h0007, 16'hFFFE, 5'h08},
		'{ALU_ADD, 1'b1, 1'b0, 1'b0, 16'h1209, 16'h0008, 16'h1211, 5'h10},
		'{ALU_ADD, 1'b1, 1'b0, 1'b0, 16'h00F0, 16'h0010, 16'h0000, 5'h03},
		'{ALU_SUB, 1'b1, 1'b0, 1'b1, 16'h0080, 16'h0001, 16'h007F, 5'h05},
		'{ALU_AND, 1'b0, 1'b0, 1'b0, 16'hF0F0, 16'h0F0F, 16'h0000, 5'h02},
		'{ALU_ASR, 1'b0, 1'b0, 1'b0, 16'h8002, 16'h0000, 16'hC001, 5'h08},
		'{ALU_SHL, 1'b0, 1'b0, 1'b0, 16'h8001, 16'h0000, 16'h0002, 5'h01},
		'{ALU_IOR, 1'b0, 1'b0, 1'b0, 16'h0000, 16'h0000, 16'h0000, 5'h02},
		'{ALU_ADD, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000, 16'h0000, 5'h02},
		'{ALU_ADD, 1'b0, 1'b1, 1'b0, 16'h0001, 16'h0001, 16'h0002, 5'h00},
		'{ALU_ADD, 1'b0, 1'b1, 1'b0, 16'h0000, 16'h0000, 16'h0000, 5'h00}};
	mul_row_t    mrow [9] = '{
		'{MUL_SS, 1'b0, 16'hFFFF, 16'hFFFF, 40'h00_0000_0001},
		'{MUL_UU, 1'b0, 16'hFFFF, 16'hFFFF, 40'h00_FFFE_0001},
		'{MUL_SU, 1'b0, 16'hFFFF, 16'h0002, 40'hFF_FFFF_FFFE},
		'{MUL_US, 1'b0, 16'hFFFF, 16'hFFFF, 40'hFF_FFFF_0001},
		'{MUL_SLIT, 1'b0, 16'h8000, 16'h0023, 40'hFF_FFFE_8000},
		'{MUL_ULIT, 1'b0, 16'h8000, 16'h0023, 40'h00_0001_8000},
		'{MUL_BYTE, 1'b0, 16'h12FF, 16'h34FF, 40'h00_0000_FE01},
		'{MUL_SS, 1'b1, 16'h8000, 16'h8000, 40'h00_8000_0000},
		'{MUL_SS, 1'b1, 16'hFFFF, 16'hFFFF, 40'h00_FFFE_0001}};
	div_row_t    drow [5] = '{
		'{1'b1, 1'b1, 32'hFFFF_FF9C, 16'h0007, 16'hFFF2, 16'hFFFE, 1'b0},
		'{1'b0, 1'b1, 32'h0001_0005, 16'h0010, 16'h1000, 16'h0005, 1'b0},
		'{1'b1, 1'b0, 32'h5555_8000, 16'hFFFD, 16'h2AAA, 16'hFFFE, 1'b0},
		'{1'b0, 1'b0, 32'hAAAA_8000, 16'h0003, 16'h2AAA, 16'h0002, 1'b0},
		'{1'b1, 1'b1, 32'h0000_0100, 16'h0000, 16'h0000, 16'h0000, 1'b1}};

	assign cb = {dsp_unsigned_select, acc_a_clamp_enable, acc_b_clamp_enable, store_clamp_enable,
		clamp_width_select, program_window_enable, round_style_select, int_mode_select};

	cpu_status_alu_multiply_divide dut (.*);
	loop_seq_model u_seq (.*);

	task automatic end_of_test;
		if (error_cnt == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [39:0] got, input logic [39:0] exp, input string s);
		total_checks++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, s);
		end
	endtask
	task automatic tmo;
		error_cnt++;
		$display("wrong value at %0t: timeout", $time);
		end_of_test;
	endtask
	// Request held until pready is seen high at an edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			tmo;
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	initial
	begin
		clk = 1'b0;
		forever
			#25 clk = ~clk;
	end

	initial
	begin
		rst = 1'b1;
		{psel, penable, pwrite, alu_go, alu_byte, alu_z_keep, alu_cin, mul_go, mul_dsp} = '0;
		{div_go, div_signed, div_wide, nesting_disable, prio_load, rep_start} = '0;
		{paddr, pwdata, alu_a, alu_b, mul_a, mul_b, div_dividend, div_divisor, prio_value} = '0;
		alu_op = ALU_ADD;
		mul_mode = MUL_SS;
		error_cnt = 0;
		total_checks = 0;
		repeat (5)
			@(posedge clk);
		rst <= 1'b0;
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0000_0220, "ctl reset");
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0, "sts reset");
		foreach (arow[i])
		begin
			@(posedge clk);
			alu_go <= 1'b1;
			alu_op <= arow[i].op;
			alu_byte <= arow[i].byt;
			alu_z_keep <= arow[i].zk;
			alu_cin <= arow[i].ci;
			alu_a <= arow[i].a;
			alu_b <= arow[i].b;
			@(posedge clk);
			alu_go <= 1'b0;
			#1;
			// Logic ops leave carry, digit carry and overflow alone
			m = (arow[i].op <= ALU_SUB) ? 5'h1F : (arow[i].op >= ALU_SHL) ? 5'h0B : 5'h0A;
			fl = {cpu_status_word[8], cpu_status_word[3:0]} & m;
			chk(alu_result, arow[i].r, "alu result");
			chk(fl, arow[i].f & m, "alu flags");
		end
		foreach (mrow[i])
		begin
			if (i == 8)
				apb(1'b1, 12'h004, 32'h0000_1001);
			@(posedge clk);
			mul_go <= 1'b1;
			mul_dsp <= mrow[i].dsp;
			mul_mode <= mrow[i].md;
			mul_a <= mrow[i].a;
			mul_b <= mrow[i].b;
			@(posedge clk);
			mul_go <= 1'b0;
			#1;
			chk(mul_product, mrow[i].p, "product");
		end
		foreach (drow[i])
		begin
			@(posedge clk);
			div_go <= 1'b1;
			div_signed <= drow[i].sg;
			div_wide <= drow[i].wd;
			div_dividend <= drow[i].n;
			div_divisor <= drow[i].d;
			repeat (4)
				@(posedge clk);
			// Second request while busy must be dropped
			div_divisor <= 16'h0000;
			@(posedge clk);
			div_go <= 1'b0;
			k = 0;
			do
			begin
				@(posedge clk);
				#1;
				k++;
			end
			while (div_done !== 1'b1 && k < 40);
			if (div_done !== 1'b1)
				tmo;
			chk(div_err, drow[i].e, "div err");
			if (drow[i].e == 1'b0)
				chk({div_quot, div_rem}, {drow[i].q, drow[i].r}, "div result");
		end
		@(posedge clk);
		prio_load <= 1'b1;
		prio_value <= 4'hF;
		@(posedge clk);
		prio_load <= 1'b0;
		#1;
		chk({user_irq_disable, core_control_word[3]}, 2'h3, "prio 15");
		apb(1'b1, 12'h004, 32'h0);
		#1;
		chk({user_irq_disable, cpu_priority_level}, 5'h17, "msb clear");
		nesting_disable <= 1'b1;
		apb(1'b1, 12'h000, 32'h0000_00B0);
		#1;
		chk(cpu_status_word[7:5], 3'h7, "locked");
		nesting_disable <= 1'b0;
		apb(1'b1, 12'h000, 32'h0000_00B0);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0000_00A0, "status rw");
		chk({user_irq_disable, cpu_priority_level}, 5'h05, "level 5");
		apb(1'b1, 12'h004, 32'h0000_FFFF);
		#1;
		chk(cb, 8'hFF, "ctl set");
		apb(1'b0, 12'h004, 32'h0);
		chk(rd, 32'h0000_11F7, "ctl read");
		apb(1'b1, 12'h004, 32'h0);
		#1;
		chk(cb, 8'h00, "ctl clear");
		@(posedge clk);
		rep_start <= 1'b1;
		@(posedge clk);
		rep_start <= 1'b0;
		#1;
		chk(cpu_status_word[4], 1'b1, "repeat");
		repeat (6)
			@(posedge clk);
		#1;
		chk(cpu_status_word[4], 1'b0, "repeat end");
		apb(1'b0, 12'h008, 32'h0);
		chk({perr, rd}, 33'h1_0000_0000, "unmapped");
		end_of_test;
	end
endmodule

bind cpu_status_alu_multiply_divide csa_assertions #(.ADDR_W(ADDR_W)) u_chk (.*);
